// file: verilog/btm_defs.svh
// constants for the upper-bank breakpoint trace-mode register block
// Operation
// - instruction breakpoints 9-14 each hold 3-bit mode
// - data breakpoints 9-14 each hold 3-bit mode
// - mode 000 stops processor and coherence tracing
// - mode 001 starts processor tracing only
// - mode 010 stops processor tracing only
// - mode 011 starts processor and coherence tracing
// - modes 100/101/111 act as 000/001/011 plus counter dump
// - counter dump always covers all counters
// - data breakpoints act only when enable set
// - more-breakpoints bit tells software use upper bank
`ifndef BTM_DEFS_SVH
`define BTM_DEFS_SVH

// ************************************************************
// register map
// ************************************************************
`define BTM_ADDR_IBKPT_HI 8'h00
`define BTM_ADDR_DBKPT_HI 8'h04
`define BTM_ADDR_DBKPT_LO 8'h08
`define BTM_ADDR_STATUS   8'h0c

// ************************************************************
// field layout and reset values
// ************************************************************
`define BTM_FIELD_W       3
`define BTM_HI_FIELDS     6
`define BTM_HI_USED_W     18
`define BTM_DE_BIT        28
`define BTM_MB_BIT        31
`define BTM_ST_PROC_BIT   0
`define BTM_ST_COH_BIT    1
`define BTM_RST_MODE      18'h00000
`define BTM_RST_DE        1'h0
`define BTM_RST_RDATA     32'h00000000
`define BTM_FIRST_HI_BKPT 9

`endif

// file: verilog/btm_pkg.sv
// types for the upper-bank breakpoint trace-mode register block
`default_nettype none
package btm_pkg;

	typedef enum logic [2:0] {
		BTM_STOP_ALL       = 3'b000,
		BTM_START_PROC     = 3'b001,
		BTM_STOP_PROC      = 3'b010,
		BTM_START_ALL      = 3'b011,
		BTM_STOP_ALL_DUMP  = 3'b100,
		BTM_START_PROC_DMP = 3'b101,
		BTM_RESERVED       = 3'b110,
		BTM_START_ALL_DUMP = 3'b111
	} btm_mode_t;

	typedef struct packed {
		logic coh_on;
		logic proc_on;
	} btm_trace_t;

endpackage
`default_nettype wire

// file: verilog/btm_top.sv
// upper-bank breakpoint trace-mode registers and trace start/stop decode
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "btm_defs.svh"

module btm_top #(
	parameter int NUM_IBKPT_HI = 6,
	parameter int NUM_DBKPT_HI = 6,
	parameter int TOTAL_BKPTS  = 15
) (
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_B_IN,
	input  wire logic [7:0]  REG_ADDR_IN,
	input  wire logic [31:0] REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	output logic      [31:0] REG_RDATA_OUT,
	input  wire logic [5:0]  IBKPT_MATCH_IN,
	input  wire logic [5:0]  DBKPT_MATCH_IN,
	output logic             PROC_TRACE_ON_OUT,
	output logic             COH_TRACE_ON_OUT,
	output logic             PERF_DUMP_OUT
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (NUM_IBKPT_HI < 0 || NUM_IBKPT_HI > `BTM_HI_FIELDS) begin : g_bad_ibkpt
		$error("instruction breakpoint count out of range");
	end
	if (NUM_DBKPT_HI < 0 || NUM_DBKPT_HI > `BTM_HI_FIELDS) begin : g_bad_dbkpt
		$error("data breakpoint count out of range");
	end
	if (TOTAL_BKPTS < `BTM_FIRST_HI_BKPT + NUM_IBKPT_HI) begin : g_bad_total
		$error("total breakpoint count too small for upper bank");
	end
	if (TOTAL_BKPTS < `BTM_FIRST_HI_BKPT + NUM_DBKPT_HI) begin : g_bad_total_d
		$error("total breakpoint count too small for data upper bank");
	end

	// ************************************************************
	// constants
	// ************************************************************
	function automatic logic [`BTM_HI_USED_W-1:0] btm_mask(input int n);
		logic [`BTM_HI_USED_W-1:0] r;
		r = '0;
		for (int i = 0; i < `BTM_HI_USED_W; i++) begin
			if (i < `BTM_FIELD_W * n) begin
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	localparam logic [`BTM_HI_USED_W-1:0] IMASK   = btm_mask(NUM_IBKPT_HI);
	localparam logic [`BTM_HI_USED_W-1:0] DMASK   = btm_mask(NUM_DBKPT_HI);
	localparam logic                      MB_VAL  = (TOTAL_BKPTS > `BTM_FIRST_HI_BKPT);
	localparam logic                      HAS_DBK = (NUM_DBKPT_HI > 0);

	// ************************************************************
	// trace action decode
	// ************************************************************
	function automatic btm_pkg::btm_trace_t btm_apply(input btm_pkg::btm_trace_t s,
	                                                  input logic [2:0] m);
		btm_pkg::btm_trace_t r;
		r = s;
		unique case (btm_pkg::btm_mode_t'(m))
			btm_pkg::BTM_STOP_ALL, btm_pkg::BTM_STOP_ALL_DUMP: begin
				r.proc_on = 1'b0;
				r.coh_on  = 1'b0;
			end
			btm_pkg::BTM_START_PROC, btm_pkg::BTM_START_PROC_DMP: begin
				r.proc_on = 1'b1;
			end
			btm_pkg::BTM_STOP_PROC: begin
				r.proc_on = 1'b0;
			end
			btm_pkg::BTM_START_ALL, btm_pkg::BTM_START_ALL_DUMP: begin
				r.proc_on = 1'b1;
				r.coh_on  = 1'b1;
			end
			btm_pkg::BTM_RESERVED: begin
				r = s;
			end
		endcase
		return r;
	endfunction

	function automatic logic btm_dumps(input logic [2:0] m);
		// upper bit requests dump except reserved code
		return m[2] && (m != 3'b110);
	endfunction

	// ************************************************************
	// register file
	// ************************************************************
	logic [`BTM_HI_USED_W-1:0] ibkpt_q;
	logic [`BTM_HI_USED_W-1:0] ibkpt_d;
	logic [`BTM_HI_USED_W-1:0] dbkpt_q;
	logic [`BTM_HI_USED_W-1:0] dbkpt_d;
	logic                      de_q;
	logic                      de_d;
	logic [31:0]               rdata_q;
	logic [31:0]               rdata_d;
	btm_pkg::btm_trace_t       trace_q;
	btm_pkg::btm_trace_t       trace_d;
	logic                      dump_q;
	logic                      dump_d;

	// writes and reads are single-cycle strobes; the slave never stalls the master
	// read data idles at zero so a stale word never lingers on the bus
	always_comb begin
		ibkpt_d = ibkpt_q;
		dbkpt_d = dbkpt_q;
		de_d    = de_q;
		rdata_d = `BTM_RST_RDATA;
		if (REG_WR_IN) begin
			unique case (REG_ADDR_IN)
				`BTM_ADDR_IBKPT_HI: begin
					ibkpt_d = REG_WDATA_IN[`BTM_HI_USED_W-1:0] & IMASK;
				end
				`BTM_ADDR_DBKPT_HI: begin
					dbkpt_d = REG_WDATA_IN[`BTM_HI_USED_W-1:0] & DMASK;
				end
				`BTM_ADDR_DBKPT_LO: begin
					de_d = REG_WDATA_IN[`BTM_DE_BIT] & HAS_DBK;
				end
				default: begin
					ibkpt_d = ibkpt_q;
				end
			endcase
		end
		if (REG_RD_IN) begin
			unique case (REG_ADDR_IN)
				`BTM_ADDR_IBKPT_HI: begin
					rdata_d[`BTM_HI_USED_W-1:0] = ibkpt_q;
				end
				`BTM_ADDR_DBKPT_HI: begin
					rdata_d[`BTM_HI_USED_W-1:0] = dbkpt_q;
				end
				`BTM_ADDR_DBKPT_LO: begin
					rdata_d[`BTM_MB_BIT] = MB_VAL;
					rdata_d[`BTM_DE_BIT] = de_q;
				end
				`BTM_ADDR_STATUS: begin
					rdata_d[`BTM_ST_PROC_BIT] = trace_q.proc_on;
					rdata_d[`BTM_ST_COH_BIT]  = trace_q.coh_on;
				end
				default: begin
					rdata_d = `BTM_RST_RDATA;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ibkpt_q <= `BTM_RST_MODE;
			dbkpt_q <= `BTM_RST_MODE;
			de_q    <= `BTM_RST_DE;
			rdata_q <= `BTM_RST_RDATA;
		end else begin
			ibkpt_q <= ibkpt_d;
			dbkpt_q <= dbkpt_d;
			de_q    <= de_d;
			rdata_q <= rdata_d;
		end
	end

	// ************************************************************
	// trace state
	// ************************************************************
	// match inputs come from same-clock logic, so they are read without a synchroniser
	// simultaneous matches apply in order, instruction then data, low index first,
	// so the highest-numbered data breakpoint has the last word
	always_comb begin
		trace_d = trace_q;
		// dump pulses once per matching cycle however many matches ask for it
		dump_d  = 1'b0;
		for (int k = 0; k < `BTM_HI_FIELDS; k++) begin
			if (k < NUM_IBKPT_HI && IBKPT_MATCH_IN[k]) begin
				trace_d = btm_apply(trace_d, ibkpt_q[`BTM_FIELD_W*k +: `BTM_FIELD_W]);
				dump_d  = dump_d | btm_dumps(ibkpt_q[`BTM_FIELD_W*k +: `BTM_FIELD_W]);
			end
		end
		for (int k = 0; k < `BTM_HI_FIELDS; k++) begin
			if (k < NUM_DBKPT_HI && DBKPT_MATCH_IN[k] && de_q) begin
				trace_d = btm_apply(trace_d, dbkpt_q[`BTM_FIELD_W*k +: `BTM_FIELD_W]);
				dump_d  = dump_d | btm_dumps(dbkpt_q[`BTM_FIELD_W*k +: `BTM_FIELD_W]);
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			trace_q <= '0;
			dump_q  <= 1'b0;
		end else begin
			trace_q <= trace_d;
			dump_q  <= dump_d;
		end
	end

	assign REG_RDATA_OUT     = rdata_q;
	assign PROC_TRACE_ON_OUT = trace_q.proc_on;
	assign COH_TRACE_ON_OUT  = trace_q.coh_on;
	assign PERF_DUMP_OUT     = dump_q;

endmodule
`default_nettype wire

// file: tb/btm_bkpt_model.sv
// breakpoint match source standing in for the core compare logic
`timescale 1ns/1ns
`default_nettype none
module btm_bkpt_model (
	input  wire logic        clk_in,
	input  wire logic [11:0] req_in,
	output logic      [5:0]  imatch_out,
	output logic      [5:0]  dmatch_out
);
	// registered like a real comparator, so matches follow the request one cycle late and last as long as it does
	always_ff @(posedge clk_in) {dmatch_out, imatch_out} <= req_in;
endmodule
`default_nettype wire

// file: tb/btm_top_sva.sv
// port assertions for the upper-bank trace-mode block
`timescale 1ns/1ns
`default_nettype none
module btm_top_sva #(
	parameter int TOTAL_BKPTS = 15
) (
	input wire logic        REF_CLK_IN,
	input wire logic        RST_B_IN,
	input wire logic [7:0]  REG_ADDR_IN,
	input wire logic [31:0] REG_WDATA_IN,
	input wire logic        REG_WR_IN,
	input wire logic        REG_RD_IN,
	input wire logic [31:0] REG_RDATA_OUT,
	input wire logic [5:0]  IBKPT_MATCH_IN,
	input wire logic [5:0]  DBKPT_MATCH_IN,
	input wire logic        PROC_TRACE_ON_OUT,
	input wire logic        COH_TRACE_ON_OUT,
	input wire logic        PERF_DUMP_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	wire logic m = |{IBKPT_MATCH_IN, DBKPT_MATCH_IN};
	// a lone match, so a later stop of the same cycle cannot split the two outputs legally
	wire logic one = $onehot({IBKPT_MATCH_IN, DBKPT_MATCH_IN});
	wire logic p = PROC_TRACE_ON_OUT;
	wire logic c = COH_TRACE_ON_OUT;
	wire logic [7:0] a = REG_ADDR_IN;
	property p_rd_idle; !$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
	property p_hi_zero; $past(REG_RD_IN) && $past(a) inside {8'h00, 8'h04} |-> REG_RDATA_OUT[31:18] == 14'h0; endproperty
	a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
	property p_more; $past(REG_RD_IN) && $past(a) == 8'h08 |-> REG_RDATA_OUT[31] == (TOTAL_BKPTS > 9); endproperty
	a_more: assert property (p_more) else $error("more bit wrong");
	property p_status; $past(REG_RD_IN) && $past(a) == 8'h0c |-> REG_RDATA_OUT[1:0] == {$past(c), $past(p)}; endproperty
	a_status: assert property (p_status) else $error("status wrong");
	property p_quiet; !m |=> $stable(p) && $stable(c) && !PERF_DUMP_OUT; endproperty
	a_quiet: assert property (p_quiet) else $error("change without match");
	property p_dump; PERF_DUMP_OUT |-> $past(m); endproperty
	a_dump: assert property (p_dump) else $error("dump without match");
	property p_coh_on; $rose(c) && $past(one) |-> p; endproperty
	a_coh_on: assert property (p_coh_on) else $error("coh on alone");
	property p_coh_off; $fell(c) && $past(one) |-> !p; endproperty
	a_coh_off: assert property (p_coh_off) else $error("coh off alone");
	c_dump: cover property (PERF_DUMP_OUT);
	c_coh: cover property ($rose(c));
	c_proc: cover property ($fell(p));
endmodule
bind btm_top btm_top_sva #(.TOTAL_BKPTS(TOTAL_BKPTS)) u_btm_top_sva (.*);
`default_nettype wire

// file: tb/test_btm_top.sv
// self-checking bench for the upper-bank trace-mode block
`timescale 1ns/1ns
`default_nettype none
module test_btm_top;
	logic        clk;
	logic        rst_b;
	logic [7:0]  addr;
	logic [31:0] wd;
	logic        wr;
	logic        rd;
	logic [11:0] req;
	logic [31:0] rdata;
	logic [5:0]  im;
	logic [5:0]  dm;
	logic        pon;
	logic        con;
	logic        dmp;
	logic        took = 1'b0;
	logic        ep = 1'b0;
	logic        ec = 1'b0;
	logic        ed = 1'b0;
	logic [31:0] seed = 32'hf42d;
	logic [31:0] v;
	logic [31:0] expq[$];
	logic [31:0] trq[$];
	logic        mt1 = 1'b0;
	logic        mt2 = 1'b0;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [2:0]  seq[11] = '{3'h1, 3'h3, 3'h0, 3'h1, 3'h2, 3'h7, 3'h4, 3'h5, 3'h6, 3'h2, 3'h3};
	// two fields left unimplemented so their refusal shows
	btm_top #(.NUM_IBKPT_HI(4)) u_btm_top (.REF_CLK_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr),
		.REG_WDATA_IN(wd), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .IBKPT_MATCH_IN(im),
		.DBKPT_MATCH_IN(dm), .PROC_TRACE_ON_OUT(pon), .COH_TRACE_ON_OUT(con), .PERF_DUMP_OUT(dmp));
	btm_bkpt_model u_btm_bkpt_model (.clk_in(clk), .req_in(req), .imatch_out(im), .dmatch_out(dm));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task end_sim();
		if (err_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// strobes drop one edge before the next task may raise them
	task wr_t(input logic [7:0] a, input logic [31:0] d);
		{addr, wd, wr} <= {a, d, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task rd_t(input logic [7:0] a, input logic [31:0] e);
		{addr, rd} <= {a, 1'b1};
		expq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask
	task trig(input logic [11:0] r, input logic [2:0] m, input logic act);
		if (act && m inside {3'h0, 3'h4}) {ec, ep} = 2'b00;
		if (act && m inside {3'h1, 3'h5}) ep = 1'b1;
		if (act && m == 3'h2) ep = 1'b0;
		if (act && m inside {3'h3, 3'h7}) {ec, ep} = 2'b11;
		ed = act && m inside {3'h4, 3'h5, 3'h7};
		trq.push_back({29'h0, ed, ec, ep});
		req <= r;
		@(posedge clk);
		req <= 12'h0;
		repeat (2) @(posedge clk);
	endtask
	// a request shows on the trace outputs two edges after it is driven, for one dump cycle
	always @(posedge clk) {mt2, mt1} <= {mt1, |req};
	always @(negedge clk) if (mt2) chk({29'h0, dmp, con, pon}, trq.pop_front());
	// read data is only valid in the cycle after the strobe
	always @(posedge clk) took <= rd;
	always @(negedge clk) if (took) chk(rdata, expq.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		{rst_b, wr, rd, req, addr, wd} = '0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd_t(8'h00, 32'h0);
		rd_t(8'h04, 32'h0);
		rd_t(8'h08, 32'h80000000);
		v = rnd();
		wr_t(8'h00, v);
		rd_t(8'h00, v & 32'hfff);
		v = rnd();
		wr_t(8'h04, v);
		rd_t(8'h04, v & 32'h3ffff);
		wr_t(8'h10, v);
		rd_t(8'h10, 32'h0);
		foreach (seq[i]) begin
			wr_t(8'h00, {14'h0, {6{seq[i]}}});
			trig({6'h0, 6'h1 << (rnd() % 4)}, seq[i], 1'b1);
		end
		rd_t(8'h0c, {30'h0, ec, ep});
		trig(12'h010, 3'h0, 1'b0);
		wr_t(8'h04, 32'h0);
		trig(12'h100, 3'h0, 1'b0);
		wr_t(8'h08, 32'h10000000);
		rd_t(8'h08, 32'h90000000);
		trig(12'h100, 3'h0, 1'b1);
		rd_t(8'h0c, {30'h0, ec, ep});
		end_sim();
	end
endmodule
`default_nettype wire
